// *** core/mb_pkg.sv ***
`default_nettype none
package mb_pkg;
	// ----------------------------------------
	// characters and check constants
	// ----------------------------------------
	localparam logic [7:0]  CH_COLON    = 8'h3A;
	localparam logic [7:0]  CH_CR       = 8'h0D;
	localparam logic [7:0]  CH_LF       = 8'h0A;
	localparam logic [7:0]  CH_ZERO     = 8'h30;
	localparam logic [7:0]  CH_NINE     = 8'h39;
	localparam logic [7:0]  CH_A        = 8'h41;
	localparam logic [7:0]  CH_F        = 8'h46;
	localparam logic [3:0]  NIB_TEN     = 4'hA;
	localparam logic [15:0] CRC_INIT    = 16'hFFFF;
	localparam logic [15:0] CRC_POLY    = 16'hA001;
	localparam logic [7:0]  ADDR_BCAST  = 8'h00;
	localparam logic [7:0]  ADDR_MAX    = 8'hFE;
	localparam logic [7:0]  BYTE_ZERO   = 8'h00;
	localparam logic [15:0] CRC_GOOD    = 16'h0000;

	// ----------------------------------------
	// function codes
	// ----------------------------------------
	localparam logic [7:0]  FC_RD_BITS     = 8'h01;
	localparam logic [7:0]  FC_RD_BITS_RO  = 8'h02;
	localparam logic [7:0]  FC_RD_WORDS    = 8'h03;
	localparam logic [7:0]  FC_RD_WORDS_RO = 8'h04;
	localparam logic [7:0]  FC_WR_BIT      = 8'h05;
	localparam logic [7:0]  FC_WR_WORD     = 8'h06;
	localparam logic [7:0]  FC_WR_BITS     = 8'h0F;
	localparam logic [7:0]  FC_WR_WORDS    = 8'h10;
	localparam logic [7:0]  FC_RW_WORDS    = 8'h17;

	// ----------------------------------------
	// frame store sizing
	// ----------------------------------------
	localparam int                ADR_W           = 6;
	localparam int                IDX_W           = 7;
	localparam logic [IDX_W-1:0]  MAX_BYTES       = 7'h40;
	localparam logic [IDX_W-1:0]  HDR_BYTES       = 7'h02;
	localparam logic [IDX_W-1:0]  ASCII_CHK_BYTES = 7'h01;
	localparam logic [IDX_W-1:0]  RTU_CHK_BYTES   = 7'h02;
	localparam logic [IDX_W-1:0]  IDX_ADDR        = 7'h00;
	localparam logic [IDX_W-1:0]  IDX_FUNC        = 7'h01;
	localparam logic [IDX_W-1:0]  ONE_BYTE        = 7'h01;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_HZ      = 200_000_000;
	localparam int MS_PER_S    = 1000;
	localparam int CYC_PER_MS  = CLK_HZ / MS_PER_S;
	localparam int TMO_300_MS  = 40;
	localparam int TMO_600_MS  = 21;
	localparam int TMO_1200_MS = 10;
	localparam int TMO_2400_MS = 5;
	localparam int TMO_4800_MS = 3;
	localparam int TMO_9600_MS = 2;
	localparam int TMO_FAST_MS = 1;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic {MODE_ASCII, MODE_RTU} mode_t;
	typedef enum logic [2:0] {BAUD_300, BAUD_600, BAUD_1200, BAUD_2400, BAUD_4800,
		BAUD_9600, BAUD_19200_UP} baud_t;
	typedef enum logic [3:0] {FN_RD_BITS, FN_RD_BITS_RO, FN_RD_WORDS, FN_RD_WORDS_RO,
		FN_WR_BIT, FN_WR_WORD, FN_WR_BITS, FN_WR_WORDS, FN_RW_WORDS, FN_OTHER} func_class_t;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [7:0] hex_char(input logic [3:0] n);
		return (n < NIB_TEN) ? CH_ZERO + {4'h0, n} : CH_A + {4'h0, n - NIB_TEN}; // [RULE3]
	endfunction

	function automatic logic is_hex(input logic [7:0] c);
		return (c >= CH_ZERO && c <= CH_NINE) || (c >= CH_A && c <= CH_F); // [RULE3]
	endfunction

	function automatic logic [3:0] hex_val(input logic [7:0] c);
		logic [7:0] d;
		d = (c <= CH_NINE) ? c - CH_ZERO : c - CH_A;
		return (c <= CH_NINE) ? d[3:0] : d[3:0] + NIB_TEN;
	endfunction

	function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic [7:0] b);
		logic [15:0] c;
		c = crc ^ {8'h00, b}; // [RULE19]
		for (int i = 0; i < 8; i++) begin
			c = c[0] ? (c >> 1) ^ CRC_POLY : (c >> 1); // [RULE19]
		end
		return c;
	endfunction

	function automatic logic [7:0] lrc_of(input logic [7:0] sum);
		return ~sum + 8'h01; // [RULE7]
	endfunction

	function automatic int tmo_ms(input baud_t b);
		case (b) // [RULE16]
			BAUD_300:  return TMO_300_MS;
			BAUD_600:  return TMO_600_MS;
			BAUD_1200: return TMO_1200_MS;
			BAUD_2400: return TMO_2400_MS;
			BAUD_4800: return TMO_4800_MS;
			BAUD_9600: return TMO_9600_MS;
			default:   return TMO_FAST_MS;
		endcase
	endfunction

	function automatic func_class_t func_class(input logic [7:0] f);
		case (f)
			FC_RD_BITS:     return FN_RD_BITS;     // [RULE11]
			FC_RD_BITS_RO:  return FN_RD_BITS_RO;  // [RULE11]
			FC_RD_WORDS:    return FN_RD_WORDS;    // [RULE11] [RULE17]
			FC_RD_WORDS_RO: return FN_RD_WORDS_RO; // [RULE11]
			FC_WR_BIT:      return FN_WR_BIT;      // [RULE12]
			FC_WR_WORD:     return FN_WR_WORD;     // [RULE12] [RULE18]
			FC_WR_BITS:     return FN_WR_BITS;     // [RULE12]
			FC_WR_WORDS:    return FN_WR_WORDS;    // [RULE12] [RULE20]
			FC_RW_WORDS:    return FN_RW_WORDS;    // [RULE13]
			default:        return FN_OTHER;
		endcase
	endfunction
endpackage
`default_nettype wire

// *** core/mb_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// byte stream from frame builder to parser
// ----------------------------------------
interface mb_link_if;
	logic [7:0] byte_data;
	logic       byte_valid;
	logic       byte_ready;

	modport host (output byte_data, output byte_valid, input byte_ready);
	modport dev  (input byte_data, input byte_valid, output byte_ready);
endinterface
`default_nettype wire

// *** core/mb_check_acc.sv ***
`timescale 1ns/1ps
`default_nettype none
module mb_check_acc (
	// clock and reset
	input  wire logic        mclk_i,
	input  wire logic        rst_i,
	// byte feed
	input  wire logic        clr_i,
	input  wire logic        en_i,
	input  wire logic [7:0]  byte_i,
	// running checks
	output logic      [7:0]  sum_o,
	output logic      [15:0] crc_o
);
	import mb_pkg::*;

	logic [7:0]  sum_base;
	logic [15:0] crc_base;

	// clear and feed may share a cycle: the byte lands on a fresh check
	assign sum_base = clr_i ? BYTE_ZERO : sum_o;
	assign crc_base = clr_i ? CRC_INIT : crc_o;

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			sum_o <= BYTE_ZERO;
			crc_o <= CRC_INIT;
		end else begin
			sum_o <= en_i ? sum_base + byte_i : sum_base; // [RULE7]
			crc_o <= en_i ? crc_step(crc_base, byte_i) : crc_base; // [RULE19]
		end
	end
endmodule
`default_nettype wire

// *** core/mb_frame_parser.sv ***
// Contract
// [RULE1] ascii frame opens with colon 3A
// [RULE2] ascii byte is two hex chars, high first
// [RULE3] hex chars 30-39 and upper-case 41-46
// [RULE4] address is one byte, two chars
// [RULE5] function byte follows address, two chars
// [RULE6] n data bytes give 2n chars
// [RULE7] lrc is negated byte sum
// [RULE8] ascii frame ends with CR then LF
// [RULE9] address 00 is broadcast, always accepted
// [RULE10] station addresses run 1 to 254
// [RULE11] codes 01-04 decode as reads
// [RULE12] codes 05 06 0F 10 decode as writes
// [RULE13] code 17 decodes as read-write words
// [RULE14] rtu address and function are raw bytes
// [RULE15] rtu crc sent low byte then high
// [RULE16] rtu silence timeout set by baud rate
// [RULE17] rtu code 03 reads consecutive registers
// [RULE18] rtu code 06 writes one register
// [RULE19] crc from FFFF, shift right, poly A001
// [RULE20] rtu code 10 writes consecutive registers
// [RULE21] rtu idle gap ends the frame
// [RULE22] bad check discards frame, flags error
// [RULE23] foreign address frames are ignored
`timescale 1ns/1ps
`default_nettype none
module mb_frame_parser #(
	parameter int MS_CYCLES = mb_pkg::CYC_PER_MS
) (
	// clock and reset
	input  wire logic                     mclk_i,
	input  wire logic                     rst_i,
	// configuration
	input  wire mb_pkg::mode_t            mode_i,
	input  wire mb_pkg::baud_t            baud_i,
	input  wire logic [7:0]               own_addr_i,
	// link
	mb_link_if.dev                        lnk,
	// frame result
	output logic                          frame_valid_o,
	output logic                          bcast_o,
	output logic      [7:0]               addr_o,
	output logic      [7:0]               func_o,
	output mb_pkg::func_class_t           class_o,
	output logic      [mb_pkg::IDX_W-1:0] len_o,
	// payload read
	input  wire logic [mb_pkg::ADR_W-1:0] rd_idx_i,
	output logic      [7:0]               rd_data_o,
	// errors
	output logic                          err_check_o,
	output logic                          err_format_o
);
	import mb_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [2:0] {ST_HUNT, ST_HI, ST_LO, ST_LF, ST_RUN} rx_state_t;

	rx_state_t        st_reg;
	rx_state_t        st_next;
	logic [7:0]       mem [MAX_BYTES];
	logic [IDX_W-1:0] cnt_reg;
	logic [IDX_W-1:0] wr_idx;
	logic [3:0]       nib_reg;
	logic             ovf_reg;
	logic [7:0]       addr_reg;
	logic [7:0]       func_reg;
	logic [31:0]      gap_reg;
	logic [31:0]      tmo_cyc;
	logic [7:0]       ch;
	logic [7:0]       sum;
	logic [15:0]      crc;
	logic             is_ascii;
	logic             take;
	logic             start;
	logic             store;
	logic [7:0]       store_byte;
	logic             finish;
	logic             fmt_err;
	logic             gap_hit;
	logic             len_ok;
	logic             chk_ok;
	logic             addr_ok;
	logic [IDX_W-1:0] chk_n;

	// parser never stalls; each byte is settled in the cycle it arrives
	assign lnk.byte_ready = 1'b1;
	assign take           = lnk.byte_valid & lnk.byte_ready;
	assign ch             = lnk.byte_data;
	assign is_ascii       = (mode_i == MODE_ASCII);
	assign tmo_cyc        = 32'(tmo_ms(baud_i) * MS_CYCLES); // [RULE16]
	assign gap_hit        = (st_reg == ST_RUN) && (gap_reg >= tmo_cyc); // [RULE21]
	assign wr_idx         = start ? IDX_ADDR : cnt_reg;

	// ----------------------------------------
	// check accumulator
	// ----------------------------------------
	mb_check_acc i_mb_check_acc (
		.mclk_i (mclk_i),
		.rst_i  (rst_i),
		.clr_i  (start),
		.en_i   (store),
		.byte_i (store_byte),
		.sum_o  (sum),
		.crc_o  (crc)
	);

	// ----------------------------------------
	// character and byte decode
	// ----------------------------------------
	always_comb begin
		st_next    = st_reg;
		start      = 1'b0;
		store      = 1'b0;
		store_byte = ch;
		finish     = 1'b0;
		fmt_err    = 1'b0;
		if (is_ascii) begin
			if (take) begin
				if (ch == CH_COLON) begin // [RULE1]
					start   = 1'b1;
					st_next = ST_HI;
				end else begin
					case (st_reg)
						ST_HI: begin
							if (is_hex(ch)) begin // [RULE2] [RULE3]
								st_next = ST_LO;
							end else if (ch == CH_CR) begin // [RULE8]
								st_next = ST_LF;
							end else begin
								fmt_err = 1'b1;
								st_next = ST_HUNT;
							end
						end
						ST_LO: begin
							if (is_hex(ch)) begin
								store      = 1'b1;
								store_byte = {nib_reg, hex_val(ch)}; // [RULE2] [RULE4] [RULE5] [RULE6]
								st_next    = ST_HI;
							end else begin
								fmt_err = 1'b1;
								st_next = ST_HUNT;
							end
						end
						ST_LF: begin
							finish  = (ch == CH_LF); // [RULE8]
							fmt_err = (ch != CH_LF);
							st_next = ST_HUNT;
						end
						default: st_next = ST_HUNT;
					endcase
				end
			end
		end else begin
			if (take) begin
				store   = 1'b1; // [RULE14]
				start   = (st_reg != ST_RUN);
				st_next = ST_RUN;
			end else if (gap_hit) begin
				finish  = 1'b1; // [RULE21]
				st_next = ST_HUNT;
			end else if (st_reg != ST_RUN) begin
				st_next = ST_HUNT;
			end
		end
	end

	// ----------------------------------------
	// frame verdict
	// ----------------------------------------
	assign chk_n   = is_ascii ? ASCII_CHK_BYTES : RTU_CHK_BYTES;
	assign len_ok  = !ovf_reg && (cnt_reg >= HDR_BYTES + chk_n);
	// sum over check byte nets zero; crc over trailing low/high bytes leaves zero
	assign chk_ok  = is_ascii ? (sum == BYTE_ZERO) : (crc == CRC_GOOD); // [RULE7] [RULE15] [RULE19]
	assign addr_ok = (addr_reg == ADDR_BCAST) || // [RULE9]
		((addr_reg == own_addr_i) && (own_addr_i <= ADDR_MAX)); // [RULE10] [RULE23]

	// ----------------------------------------
	// state and capture
	// ----------------------------------------
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			st_reg <= ST_HUNT;
		end else begin
			st_reg <= st_next;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			nib_reg <= 4'h0;
		end else if (take && st_reg == ST_HI && is_hex(ch)) begin
			nib_reg <= hex_val(ch); // [RULE2]
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_reg  <= IDX_ADDR;
			ovf_reg  <= 1'b0;
			addr_reg <= BYTE_ZERO;
			func_reg <= BYTE_ZERO;
		end else begin
			if (start) begin
				cnt_reg <= IDX_ADDR;
				ovf_reg <= 1'b0;
			end
			if (store) begin
				if (wr_idx < MAX_BYTES) begin
					cnt_reg <= wr_idx + ONE_BYTE;
				end else begin
					ovf_reg <= 1'b1;
				end
				if (wr_idx == IDX_ADDR) begin
					addr_reg <= store_byte; // [RULE4] [RULE14]
				end
				if (wr_idx == IDX_FUNC) begin
					func_reg <= store_byte; // [RULE5] [RULE14]
				end
			end
		end
	end

	// no reset on the frame store: it is only read inside a counted frame
	always_ff @(posedge mclk_i) begin
		if (store && wr_idx < MAX_BYTES) begin
			mem[wr_idx[ADR_W-1:0]] <= store_byte;
		end
	end

	// ----------------------------------------
	// silence timer
	// ----------------------------------------
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			gap_reg <= '0;
		end else if (take || st_reg != ST_RUN) begin
			gap_reg <= '0; // [RULE21]
		end else if (!gap_hit) begin
			gap_reg <= gap_reg + 32'h0000_0001;
		end
	end

	// ----------------------------------------
	// results
	// ----------------------------------------
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			frame_valid_o <= 1'b0;
			err_check_o   <= 1'b0;
			err_format_o  <= 1'b0;
		end else begin
			frame_valid_o <= finish && len_ok && chk_ok && addr_ok; // [RULE22] [RULE23]
			err_check_o   <= finish && len_ok && !chk_ok; // [RULE22]
			err_format_o  <= fmt_err || (finish && !len_ok);
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			bcast_o <= 1'b0;
			addr_o  <= BYTE_ZERO;
			func_o  <= BYTE_ZERO;
			class_o <= FN_OTHER;
			len_o   <= IDX_ADDR;
		end else if (finish && len_ok && chk_ok && addr_ok) begin
			bcast_o <= (addr_reg == ADDR_BCAST); // [RULE9]
			addr_o  <= addr_reg;
			func_o  <= func_reg;
			class_o <= func_class(func_reg); // [RULE11] [RULE12] [RULE13] [RULE17] [RULE18] [RULE20]
			len_o   <= cnt_reg - HDR_BYTES - chk_n; // [RULE6]
		end
	end

	// payload read; a following frame overwrites the store, so read before it arrives
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			rd_data_o <= BYTE_ZERO;
		end else begin
			rd_data_o <= mem[rd_idx_i + HDR_BYTES[ADR_W-1:0]];
		end
	end
endmodule
`default_nettype wire

// *** core/mb_frame_builder.sv ***
`timescale 1ns/1ps
`default_nettype none
module mb_frame_builder #(
	parameter int MS_CYCLES = mb_pkg::CYC_PER_MS
) (
	// clock and reset
	input  wire logic                     mclk_i,
	input  wire logic                     rst_i,
	// configuration
	input  wire mb_pkg::mode_t            mode_i,
	input  wire mb_pkg::baud_t            baud_i,
	// request
	input  wire logic                     req_valid_i,
	output logic                          req_ready_o,
	input  wire logic [7:0]               addr_i,
	input  wire logic [7:0]               func_i,
	input  wire logic [mb_pkg::IDX_W-1:0] len_i,
	// payload
	input  wire logic                     dat_valid_i,
	output logic                          dat_ready_o,
	input  wire logic [7:0]               dat_i,
	// status
	output logic                          busy_o,
	// link
	mb_link_if.host                       lnk
);
	import mb_pkg::*;

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef enum logic [3:0] {TS_IDLE, TS_SOF, TS_ADDR, TS_FUNC, TS_DATA, TS_CHK, TS_CHK2,
		TS_CR, TS_LF, TS_GAP} tx_state_t;

	tx_state_t        st_reg;
	tx_state_t        st_next;
	tx_state_t        after_st;
	logic             ascii_reg;
	logic [7:0]       addr_reg;
	logic [7:0]       func_reg;
	logic [IDX_W-1:0] left_reg;
	logic [7:0]       hold_reg;
	logic             phase_reg;
	logic             out_vld_reg;
	logic [7:0]       out_dat_reg;
	logic [31:0]      gap_reg;
	logic [31:0]      tmo_cyc;
	logic [7:0]       cur_byte;
	logic [7:0]       emit_dat;
	logic [7:0]       sum;
	logic [15:0]      crc;
	logic             slot_free;
	logic             accept;
	logic             emit;
	logic             done_byte;
	logic             feed;

	assign slot_free      = !out_vld_reg || lnk.byte_ready;
	assign req_ready_o    = (st_reg == TS_IDLE);
	assign accept         = req_valid_i && req_ready_o;
	assign busy_o         = (st_reg != TS_IDLE);
	assign dat_ready_o    = slot_free && st_reg == TS_DATA && !phase_reg;
	assign lnk.byte_valid = out_vld_reg;
	assign lnk.byte_data  = out_dat_reg;
	assign tmo_cyc        = 32'(tmo_ms(baud_i) * MS_CYCLES);

	mb_check_acc i_mb_check_acc (
		.mclk_i (mclk_i),
		.rst_i  (rst_i),
		.clr_i  (accept),
		.en_i   (feed),
		.byte_i (cur_byte),
		.sum_o  (sum),
		.crc_o  (crc)
	);

	// ----------------------------------------
	// next character
	// ----------------------------------------
	always_comb begin
		cur_byte = BYTE_ZERO;
		after_st = TS_IDLE;
		case (st_reg)
			TS_ADDR: begin
				cur_byte = addr_reg; // [RULE4] [RULE14]
				after_st = TS_FUNC;
			end
			TS_FUNC: begin
				cur_byte = func_reg; // [RULE5] [RULE14]
				after_st = (left_reg == IDX_ADDR) ? TS_CHK : TS_DATA;
			end
			TS_DATA: begin
				cur_byte = dat_i; // [RULE6]
				after_st = (left_reg == ONE_BYTE) ? TS_CHK : TS_DATA;
			end
			TS_CHK: begin
				cur_byte = ascii_reg ? lrc_of(sum) : crc[7:0]; // [RULE7] [RULE15]
				after_st = ascii_reg ? TS_CR : TS_CHK2;
			end
			TS_CHK2: begin
				cur_byte = crc[15:8]; // [RULE15]
				after_st = TS_GAP;
			end
			default: ;
		endcase
	end

	always_comb begin
		st_next   = st_reg;
		emit      = 1'b0;
		emit_dat  = BYTE_ZERO;
		done_byte = 1'b0;
		case (st_reg)
			TS_IDLE: begin
				if (accept) begin
					st_next = (mode_i == MODE_ASCII) ? TS_SOF : TS_ADDR;
				end
			end
			TS_SOF: begin
				emit     = slot_free;
				emit_dat = CH_COLON; // [RULE1]
				st_next  = slot_free ? TS_ADDR : st_reg;
			end
			TS_CR: begin
				emit     = slot_free;
				emit_dat = CH_CR; // [RULE8]
				st_next  = slot_free ? TS_LF : st_reg;
			end
			TS_LF: begin
				emit     = slot_free;
				emit_dat = CH_LF; // [RULE8]
				st_next  = slot_free ? TS_IDLE : st_reg;
			end
			TS_GAP: begin
				// silence counts only once the last byte has left
				if (!out_vld_reg && gap_reg >= tmo_cyc) begin
					st_next = TS_IDLE;
				end
			end
			default: begin
				if (slot_free && (st_reg != TS_DATA || phase_reg || dat_valid_i)) begin
					emit = 1'b1;
					if (ascii_reg) begin
						emit_dat  = phase_reg ? hex_char(hold_reg[3:0]) : hex_char(cur_byte[7:4]); // [RULE2]
						done_byte = phase_reg;
					end else begin
						emit_dat  = cur_byte; // [RULE14]
						done_byte = 1'b1;
					end
					st_next = done_byte ? after_st : st_reg;
				end
			end
		endcase
	end

	assign feed = emit && !phase_reg && (st_reg inside {TS_ADDR, TS_FUNC, TS_DATA});

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			st_reg <= TS_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			ascii_reg <= 1'b0;
			addr_reg  <= BYTE_ZERO;
			func_reg  <= BYTE_ZERO;
			left_reg  <= IDX_ADDR;
		end else if (accept) begin
			ascii_reg <= (mode_i == MODE_ASCII);
			addr_reg  <= addr_i;
			func_reg  <= func_i;
			left_reg  <= len_i;
		end else if (done_byte && st_reg == TS_DATA) begin
			left_reg  <= left_reg - ONE_BYTE;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			hold_reg  <= BYTE_ZERO;
			phase_reg <= 1'b0;
		end else if (emit && ascii_reg && !(st_reg inside {TS_SOF, TS_CR, TS_LF})) begin
			hold_reg  <= phase_reg ? hold_reg : cur_byte;
			phase_reg <= !phase_reg;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			out_vld_reg <= 1'b0;
			out_dat_reg <= BYTE_ZERO;
		end else if (emit) begin
			out_vld_reg <= 1'b1;
			out_dat_reg <= emit_dat;
		end else if (lnk.byte_ready) begin
			out_vld_reg <= 1'b0;
		end
	end

	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			gap_reg <= '0;
		end else if (st_reg != TS_GAP || out_vld_reg) begin
			gap_reg <= '0;
		end else if (gap_reg < tmo_cyc) begin
			gap_reg <= gap_reg + 32'h0000_0001;
		end
	end
endmodule
`default_nettype wire

// *** dv/mb_link_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module mb_link_checker (
	// clock, reset, mode
	input wire logic          mclk_i,
	input wire logic          rst_i,
	input wire mb_pkg::mode_t mode_i,
	// link
	input wire logic [7:0]    byte_data,
	input wire logic          byte_valid,
	input wire logic          byte_ready
);
	import mb_pkg::*;
	logic       a, t, h, c, cr, lf;
	logic [3:0] v, hi_reg;
	logic [7:0] sum_reg;
	logic       half_reg;
	assign a = mode_i == MODE_ASCII;
	assign t = byte_valid && byte_ready && a;
	assign h = (byte_data >= CH_ZERO && byte_data <= CH_NINE) || (byte_data >= CH_A && byte_data <= CH_F);
	assign v = (byte_data <= CH_NINE) ? byte_data[3:0] : byte_data[3:0] + 4'h9;
	assign c = t && byte_data == CH_COLON;
	assign cr = t && byte_data == CH_CR;
	assign lf = t && byte_data == CH_LF;
	// nibble pairing, restarted by every colon
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			half_reg <= 1'b0;
			hi_reg <= 4'h0;
		end else if (c) begin
			half_reg <= 1'b0;
			hi_reg <= 4'h0;
		end else if (t && h) begin
			half_reg <= ~half_reg;
			hi_reg <= v;
		end
	end
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			sum_reg <= 8'h00;
		end else if (c) begin
			sum_reg <= 8'h00;
		end else if (t && h && half_reg) begin
			sum_reg <= sum_reg + {hi_reg, v};
		end
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	chk_colon_first: assert property (a && $rose(byte_valid) |-> byte_data == CH_COLON)
		else $error("frame did not open with colon");
	chk_addr_follows: assert property (c |=> byte_valid && h)
		else $error("no hex char after colon");
	chk_hex_only: assert property (t && !c && !cr && !lf |-> h)
		else $error("char outside hex set");
	chk_even_chars: assert property (cr |-> !half_reg)
		else $error("odd hex char count");
	chk_lrc_zero: assert property (cr |-> sum_reg == 8'h00)
		else $error("byte sum with check not zero");
	chk_lf_after_cr: assert property (cr |=> byte_valid && byte_data == CH_LF)
		else $error("CR not followed by LF");
	chk_lf_last: assert property (lf |=> !byte_valid)
		else $error("char after LF");
	chk_rtu_silence: assert property (!a && $fell(byte_valid) |-> !byte_valid [*8])
		else $error("rtu frame without silence");
	cover property (lf);
	cover property (c);
	cover property (!a && $fell(byte_valid));
endmodule
`default_nettype wire

// *** dv/tb_modbus_ascii_rtu_framer.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_modbus_ascii_rtu_framer;
	import mb_pkg::*;
	logic        mclk_i, rst_i, req_valid, req_ready, dat_valid, dat_ready, fv, bc;
	mode_t       mode;
	baud_t       baud;
	logic [7:0]  own, ad, fc, ao, fo;
	logic [7:0]  pl [4];
	logic [6:0]  ln, lo;
	func_class_t co;
	int          mismatches, comparisons, di, cyc, last_t;
	logic [7:0]  wq [$];
	logic [5:0]  ri;
	logic [7:0]  rd;
	logic        bz, ec, ef;
	int          nec, nef;
	mb_link_if lnk ();
	// short millisecond keeps rtu gaps at 10 to 400 cycles
	mb_frame_builder #(.MS_CYCLES(10)) i_mb_frame_builder (.mclk_i(mclk_i), .rst_i(rst_i), .mode_i(mode),
		.baud_i(baud), .req_valid_i(req_valid), .req_ready_o(req_ready), .addr_i(ad), .func_i(fc), .len_i(ln),
		.dat_valid_i(dat_valid), .dat_ready_o(dat_ready), .dat_i(pl[di[1:0]]), .busy_o(bz), .lnk(lnk.host));
	mb_frame_parser #(.MS_CYCLES(10)) i_mb_frame_parser (.mclk_i(mclk_i), .rst_i(rst_i), .mode_i(mode),
		.baud_i(baud), .own_addr_i(own), .lnk(lnk.dev), .frame_valid_o(fv), .bcast_o(bc), .addr_o(ao),
		.func_o(fo), .class_o(co), .len_o(lo), .rd_idx_i(ri), .rd_data_o(rd), .err_check_o(ec), .err_format_o(ef));
	mb_link_checker i_mb_link_checker (.mclk_i(mclk_i), .rst_i(rst_i), .mode_i(mode), .byte_data(lnk.byte_data),
		.byte_valid(lnk.byte_valid), .byte_ready(lnk.byte_ready));
	assign dat_valid = di < ln;
	initial begin
		mclk_i = 1'b0;
		forever #2.5 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (dat_valid && dat_ready) di <= di + 1;
		if (ec === 1'b1) nec <= nec + 1;
		if (ef === 1'b1) nef <= nef + 1;
		if (lnk.byte_valid && lnk.byte_ready) begin
			wq.push_back(lnk.byte_data);
			last_t <= cyc;
		end
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		if (mismatches == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	function automatic logic [7:0] hx(input logic [3:0] n);
		return n < 4'hA ? 8'h30 + n : 8'h37 + n;
	endfunction
	task automatic frame(input mode_t m, input logic [7:0] a, f, input int n, output bit got);
		int k;
		for (k = 0; k < 1000 && req_ready !== 1'b1; k++) @(negedge mclk_i);
		mode = m;
		ad = a;
		fc = f;
		ln = n[6:0];
		di = 0;
		wq.delete();
		req_valid = 1'b1;
		@(negedge mclk_i);
		req_valid = 1'b0;
		check(16'(bz), 16'h0001);
		got = 1'b0;
		for (k = 0; k < 600 && !got; k++) begin
			@(negedge mclk_i);
			got = fv === 1'b1;
		end
	endtask
	task automatic cmpq(input logic [7:0] e [$]);
		check(16'(wq.size()), 16'(e.size()));
		foreach (e[i]) check(wq[i], e[i]);
	endtask
	task automatic t_ascii();
		logic [7:0] e [$];
		logic [7:0] s;
		bit g;
		own = 8'h01;
		frame(MODE_ASCII, 8'h01, FC_RD_WORDS, 4, g);
		check(16'(g), 16'h0001);
		check({ao, fo}, 16'h0103);
		check(16'(lo), 16'h0004);
		s = 8'h04;
		e = {CH_COLON, hx(4'h0), hx(4'h1), hx(4'h0), hx(4'h3)};
		foreach (pl[i]) begin
			s += pl[i];
			e.push_back(hx(pl[i][7:4]));
			e.push_back(hx(pl[i][3:0]));
		end
		s = ~s + 8'h01;
		e = {e, hx(s[7:4]), hx(s[3:0]), CH_CR, CH_LF};
		cmpq(e);
		ri = 6'h01;
		@(negedge mclk_i);
		check(16'(rd), 16'(pl[1]));
	endtask
	task automatic t_rtu();
		bit g;
		baud = BAUD_300;
		frame(MODE_RTU, 8'h01, FC_RD_WORDS, 4, g);
		check(16'(g), 16'h0001);
		check(16'(co), 16'(FN_RD_WORDS));
		check(16'(cyc - last_t > 399 && cyc - last_t < 410), 16'h0001);
		cmpq({8'h01, 8'h03, pl[0], pl[1], pl[2], pl[3], 8'h6F, 8'hF7});
	endtask
	task automatic t_codes();
		logic [7:0] c [9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0F, 8'h10, 8'h17};
		bit g;
		for (int m = 0; m < 2; m++) begin
			foreach (c[i]) begin
				frame(mode_t'(m), 8'h01, c[i], 0, g);
				check(16'({g, fo}), 16'({1'b1, c[i]}));
				check(16'(co), 16'(func_class_t'(4'(i))));
			end
		end
	endtask
	task automatic t_addr();
		bit g;
		own = 8'h05;
		frame(MODE_ASCII, ADDR_BCAST, FC_WR_WORD, 1, g);
		check(16'({g, bc}), 16'h0003);
		frame(MODE_ASCII, 8'h07, FC_WR_WORD, 1, g);
		check(16'(g), 16'h0000);
		own = ADDR_MAX;
		frame(MODE_ASCII, ADDR_MAX, FC_WR_WORD, 1, g);
		check(16'({g, bc, ao}), 16'({2'b10, ADDR_MAX}));
	endtask
	// more data than the frame store holds must end in a format error
	task automatic t_long();
		bit g;
		frame(MODE_ASCII, ADDR_MAX, FC_WR_WORDS, 70, g);
		check(16'(g), 16'h0000);
		check(16'(nef), 16'h0001);
		check(16'(nec), 16'h0000);
	endtask
	initial begin
		rst_i = 1'b1;
		req_valid = 1'b0;
		mode = MODE_ASCII;
		baud = BAUD_19200_UP;
		{own, ad, fc, ln} = '0;
		{di, cyc, last_t, mismatches, comparisons, nec, nef} = '0;
		ri = 6'h00;
		pl = '{8'h21, 8'h02, 8'h00, 8'h02};
		repeat (6) @(negedge mclk_i);
		rst_i = 1'b0;
		t_ascii();
		t_codes();
		t_rtu();
		t_addr();
		t_long();
		test_done();
	end
	// whole run is a few thousand cycles
	initial begin
		#60000;
		mismatches++;
		test_done();
	end
endmodule
`default_nettype wire
